// file: rtl/acd_pkg.sv
// Constants, register map and opcode decoding for the command class decoder
// How it works
// - Busy or data request held until completion
// - Busy falling edge raises the interrupt request
// - Only reset, link reset or software reset aborts
// - Status read, reset, opcode write clear interrupt
// - PIO in moves 512-byte sectors to host
// - PIO out takes 512-byte sectors from host
// - Non-data commands have no data phase
// - DMA class moves blocks by DMA
// - Queued commands move blocks by DMA, length from feature
// - Count bit 7 carries queued priority
// - Priority is only a soft preference
// - Opcode B4 sanitize family is non-data for four feature codes, other features unknown
// - Opcode B1 configuration family by feature
// - F8 and 27 are non-data
// - 40, 41, 42 are non-data
// - B4 feature selects the sanitize subcommand
// - Class codes one to five
package acd_pkg;

  // Register byte offsets
  localparam logic [7:0] ACD_OFF_CMD = 8'h00;
  localparam logic [7:0] ACD_OFF_FEAT = 8'h04;
  localparam logic [7:0] ACD_OFF_COUNT = 8'h08;
  localparam logic [7:0] ACD_OFF_STATUS = 8'h0c;
  localparam logic [7:0] ACD_OFF_CLASS = 8'h10;
  localparam logic [7:0] ACD_OFF_CTRL = 8'h14;
  localparam logic [7:0] ACD_OFF_ERROR = 8'h18;

  // Status register bit positions
  localparam int ACD_ST_BSY = 7;
  localparam int ACD_ST_RDY = 6;
  localparam int ACD_ST_DRQ = 3;
  localparam int ACD_ST_ERR = 0;
  // Error register abort bit, control register software reset bit
  localparam int ACD_ER_ABRT = 2;
  localparam int ACD_CT_SRST = 2;
  // Priority bit of the count field for queued commands
  localparam int ACD_PRIO_BIT = 7;
  // Class register field positions
  localparam int ACD_CL_PRIO = 3;
  localparam int ACD_CL_QUEUED = 4;
  localparam int ACD_CL_LEFT = 8;

  // Reset values
  localparam logic [15:0] ACD_RST_FIELD = 16'h0000;
  localparam logic [7:0] ACD_RST_OPCODE = 8'h00;

  // Protocol class codes
  localparam logic [2:0] ACD_CLS_NONE = 3'h0;
  localparam logic [2:0] ACD_CLS_PIO_IN = 3'h1;
  localparam logic [2:0] ACD_CLS_PIO_OUT = 3'h2;
  localparam logic [2:0] ACD_CLS_NODATA = 3'h3;
  localparam logic [2:0] ACD_CLS_DMA = 3'h4;
  localparam logic [2:0] ACD_CLS_QUEUED = 3'h5;

  // Sanitize subcommand feature codes
  localparam logic [15:0] ACD_SAN_STATUS = 16'h0000;
  localparam logic [15:0] ACD_SAN_CRYPTO = 16'h0011;
  localparam logic [15:0] ACD_SAN_OVERWRITE = 16'h0014;
  localparam logic [15:0] ACD_SAN_FREEZE = 16'h0020;
  // Configuration family feature codes (plain defaults)
  localparam logic [7:0] ACD_CFG_RESTORE = 8'hc0;
  localparam logic [7:0] ACD_CFG_FREEZE = 8'hc1;
  localparam logic [7:0] ACD_CFG_IDENTIFY = 8'hc2;
  localparam logic [7:0] ACD_CFG_SET = 8'hc3;

  // Sector geometry: 512 bytes in 32-bit words
  localparam int ACD_SECTOR_BYTES = 512;
  localparam logic [6:0] ACD_WORDS_LAST = 7'(ACD_SECTOR_BYTES / 4 - 1);

  // Internal execution time of a non-data command
  localparam int ACD_EXEC_NS = 40;
  localparam int ACD_CLK_NS = 10;
  localparam logic [3:0] ACD_EXEC_CYC = 4'((ACD_EXEC_NS + ACD_CLK_NS - 1) / ACD_CLK_NS);

  // AXI responses
  localparam logic [1:0] ACD_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACD_RESP_SLVERR = 2'h2;

  // Command sequencer states
  typedef enum logic [5:0] {
    ACD_S_IDLE = 6'b000001,
    ACD_S_DECODE = 6'b000010,
    ACD_S_EXEC = 6'b000100,
    ACD_S_PIO = 6'b001000,
    ACD_S_DMA = 6'b010000,
    ACD_S_END = 6'b100000
  } acd_state_type;

endpackage : acd_pkg

// file: rtl/acd_command_decoder.sv
// Command class decoder with protocol handshake and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module acd_command_decoder
  import acd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // Link-side reset request
  input wire logic comReset,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Data path toward the media side
  input wire logic wordStrobe,
  output logic xferActive,
  output logic xferToHost,
  output logic xferDma,
  // Protocol flags and decoded class
  output logic busy,
  output logic dataReq,
  output logic intReq,
  output logic [2:0] cmdClass,
  output logic prioHigh
);

  // Opcode and feature to protocol class
  function automatic logic [2:0] classOf(input logic [7:0] op, input logic [15:0] feat);
    logic [2:0] c;
    c = ACD_CLS_NONE;
    unique casez (op)
      8'hec, 8'he4, 8'h2f, 8'hc4, 8'h29, 8'h20, 8'h21, 8'h24, 8'h2b: c = ACD_CLS_PIO_IN;
      8'h92, 8'h50, 8'hf6, 8'hf4, 8'hf1, 8'hf2, 8'he8, 8'h3f: c = ACD_CLS_PIO_OUT;
      8'hc5, 8'h39, 8'hce, 8'h30, 8'h31, 8'h34, 8'h3b: c = ACD_CLS_PIO_OUT;
      8'he5, 8'h98, 8'h51, 8'h90, 8'he7, 8'hea, 8'he3, 8'h97: c = ACD_CLS_NODATA;
      8'he1, 8'h95, 8'h91, 8'h63, 8'hf3, 8'hf5, 8'hef, 8'hf9: c = ACD_CLS_NODATA;
      8'h37, 8'hc6, 8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94: c = ACD_CLS_NODATA;
      8'h45, 8'h1?, 8'h7?: c = ACD_CLS_NODATA;
      8'hf8, 8'h27: c = ACD_CLS_NODATA;
      8'h40, 8'h41, 8'h42: c = ACD_CLS_NODATA;
      8'hc8, 8'hc9, 8'h25, 8'h47, 8'h2a, 8'hca, 8'hcb: c = ACD_CLS_DMA;
      8'h35, 8'h3d, 8'h57, 8'h3a: c = ACD_CLS_DMA;
      8'h60, 8'h61: c = ACD_CLS_QUEUED;
      // Sanitize family, non-data for the four listed feature codes, any other feature unknown
      8'hb4: begin
        if (feat == ACD_SAN_STATUS || feat == ACD_SAN_CRYPTO ||
            feat == ACD_SAN_OVERWRITE || feat == ACD_SAN_FREEZE) begin
          c = ACD_CLS_NODATA;
        end
      end
      // Configuration family
      8'hb1: begin
        if (feat[7:0] == ACD_CFG_IDENTIFY) begin
          c = ACD_CLS_PIO_IN;
        end else if (feat[7:0] == ACD_CFG_SET) begin
          c = ACD_CLS_PIO_OUT;
        end else if (feat[7:0] == ACD_CFG_RESTORE || feat[7:0] == ACD_CFG_FREEZE) begin
          c = ACD_CLS_NODATA;
        end
      end
      // Health monitoring family, class chosen by feature
      8'hb0: begin
        unique case (feat[7:0])
          8'hd0, 8'hd1, 8'hd5: c = ACD_CLS_PIO_IN;
          8'hd6: c = ACD_CLS_PIO_OUT;
          8'hd2, 8'hd3, 8'hd4, 8'hd8, 8'hd9, 8'hda, 8'hdb: c = ACD_CLS_NODATA;
          default: c = ACD_CLS_NONE;
        endcase
      end
      default: c = ACD_CLS_NONE;
    endcase
    return c;
  endfunction : classOf

  // Register file and command state
  logic [7:0] opcode_q; // Last opcode accepted
  logic [15:0] feat_q; // Feature field
  logic [15:0] count_q; // Sector count field
  logic [2:0] class_q; // Decoded class of current command
  logic prio_q; // Queued priority class
  logic err_q; // Last command ended in error
  logic abrt_q; // Abort cause
  logic ready_q; // Device ready flag
  logic int_q; // Pending interrupt
  logic [8:0] secLeft_q; // Sectors still to move
  logic [6:0] word_q; // Word index within a sector
  logic [3:0] exec_q; // Non-data execution countdown
  acd_state_type state_q;
  acd_state_type state_d;

  // AXI write and read path holding registers
  logic awHave_q;
  logic wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;

  // Derived strobes
  logic wrFire; // Both address and data present
  logic rdFire; // Read address taken
  logic cmdWrite; // Opcode register written
  logic srstWrite; // Software reset requested
  logic stRead; // Status register read
  logic anyReset; // Any reset of command state
  logic accept; // Command accepted
  logic sectorEnd; // Last word of a sector seen
  logic lastSector; // Current sector is the final one
  logic busyFall; // Busy about to drop in a command
  logic [2:0] newClass; // Class of opcode being written

  assign wrFire = awHave_q && wHave_q && !bValid_q;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign cmdWrite = wrFire && awAddr_q == ACD_OFF_CMD && wStrb_q[0];
  assign srstWrite = wrFire && awAddr_q == ACD_OFF_CTRL && wStrb_q[0] && wData_q[ACD_CT_SRST];
  assign stRead = rdFire && s_axi_araddr == ACD_OFF_STATUS;
  // Only reset, link reset and software reset end a running command
  assign anyReset = rst || comReset || srstWrite;
  // Opcode writes outside idle are dropped, host must wait for idle and ready
  assign accept = cmdWrite && state_q == ACD_S_IDLE && ready_q;
  assign newClass = classOf(wData_q[7:0], feat_q);
  assign sectorEnd = wordStrobe && word_q == ACD_WORDS_LAST;
  assign lastSector = secLeft_q == 9'h001;
  assign busyFall = state_q == ACD_S_END || (state_q == ACD_S_DECODE && state_d == ACD_S_PIO);

  // AXI handshake outputs
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // Write address and data capture, in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else begin
      // Address channel
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
        awHave_q <= 1'b0;
      end
      // Data channel
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
        wHave_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q <= ACD_RESP_OKAY;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      // Read-only and unmapped offsets answer with an error
      if (awAddr_q == ACD_OFF_CMD || awAddr_q == ACD_OFF_FEAT || awAddr_q == ACD_OFF_COUNT ||
          awAddr_q == ACD_OFF_CTRL) begin
        bResp_q <= ACD_RESP_OKAY;
      end else begin
        bResp_q <= ACD_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Read data path
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= ACD_RESP_OKAY;
    end else if (rdFire) begin
      rValid_q <= 1'b1;
      rResp_q <= ACD_RESP_OKAY;
      rData_q <= 32'h00000000;
      unique case (s_axi_araddr)
        ACD_OFF_CMD: rData_q[7:0] <= opcode_q;
        ACD_OFF_FEAT: rData_q[15:0] <= feat_q;
        ACD_OFF_COUNT: rData_q[15:0] <= count_q;
        ACD_OFF_STATUS: begin
          rData_q[ACD_ST_BSY] <= busy;
          rData_q[ACD_ST_RDY] <= ready_q;
          rData_q[ACD_ST_DRQ] <= dataReq;
          rData_q[ACD_ST_ERR] <= err_q;
        end
        ACD_OFF_CLASS: begin
          rData_q[2:0] <= class_q;
          rData_q[ACD_CL_PRIO] <= prio_q;
          rData_q[ACD_CL_QUEUED] <= class_q == ACD_CLS_QUEUED && state_q != ACD_S_IDLE;
          rData_q[ACD_CL_LEFT +: 9] <= secLeft_q;
        end
        ACD_OFF_CTRL: rData_q <= 32'h00000000;
        ACD_OFF_ERROR: rData_q[ACD_ER_ABRT] <= abrt_q;
        default: rResp_q <= ACD_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // Feature and count fields, writable only while idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      feat_q <= ACD_RST_FIELD;
      count_q <= ACD_RST_FIELD;
    end else if (wrFire && state_q == ACD_S_IDLE) begin
      if (awAddr_q == ACD_OFF_FEAT) begin
        if (wStrb_q[0]) feat_q[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) feat_q[15:8] <= wData_q[15:8];
      end
      if (awAddr_q == ACD_OFF_COUNT) begin
        if (wStrb_q[0]) count_q[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) count_q[15:8] <= wData_q[15:8];
      end
    end
  end

  // Device ready rises the cycle after any reset ends
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ACD_S_IDLE: if (accept) state_d = ACD_S_DECODE;
      ACD_S_DECODE: begin
        unique case (class_q)
          ACD_CLS_PIO_IN, ACD_CLS_PIO_OUT: state_d = ACD_S_PIO;
          ACD_CLS_NODATA: state_d = ACD_S_EXEC;
          ACD_CLS_DMA, ACD_CLS_QUEUED: state_d = ACD_S_DMA;
          default: state_d = ACD_S_END;
        endcase
      end
      ACD_S_EXEC: if (exec_q == 4'h1) state_d = ACD_S_END;
      ACD_S_PIO, ACD_S_DMA: if (sectorEnd && lastSector) state_d = ACD_S_END;
      ACD_S_END: state_d = ACD_S_IDLE;
      default: state_d = ACD_S_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      state_q <= ACD_S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Command capture and decoding at acceptance
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      opcode_q <= ACD_RST_OPCODE;
      class_q <= ACD_CLS_NONE;
      prio_q <= 1'b0;
      err_q <= 1'b0;
      abrt_q <= 1'b0;
    end else if (accept) begin
      opcode_q <= wData_q[7:0];
      class_q <= newClass;
      prio_q <= newClass == ACD_CLS_QUEUED && count_q[ACD_PRIO_BIT];
      err_q <= newClass == ACD_CLS_NONE;
      abrt_q <= newClass == ACD_CLS_NONE;
    end
  end

  // Transfer length: sectors from count, zero meaning 256; queued uses feature
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      secLeft_q <= 9'h000;
      word_q <= 7'h00;
    end else if (accept) begin
      word_q <= 7'h00;
      if (newClass == ACD_CLS_QUEUED) begin
        secLeft_q <= (feat_q[7:0] == 8'h00) ? 9'h100 : {1'b0, feat_q[7:0]};
      end else begin
        secLeft_q <= (count_q[7:0] == 8'h00) ? 9'h100 : {1'b0, count_q[7:0]};
      end
    end else if ((state_q == ACD_S_PIO || state_q == ACD_S_DMA) && wordStrobe) begin
      // One 32-bit word per strobe, 128 per sector
      word_q <= 7'(word_q + 7'h01);
      if (sectorEnd) begin
        secLeft_q <= 9'(secLeft_q - 9'h001);
      end
    end
  end

  // Non-data execution countdown
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      exec_q <= 4'h0;
    end else if (state_q == ACD_S_DECODE) begin
      exec_q <= ACD_EXEC_CYC;
    end else if (state_q == ACD_S_EXEC) begin
      exec_q <= 4'(exec_q - 4'h1);
    end
  end

  // Pending interrupt: busy falling sets it, status read or opcode write clears; set wins
  always_ff @(posedge ref_clk) begin
    if (anyReset) begin
      int_q <= 1'b0;
    end else if (busyFall) begin
      int_q <= 1'b1;
    end else if (stRead || cmdWrite) begin
      int_q <= 1'b0;
    end
  end

  // Busy through decode, execution, DMA and end; request while PIO data moves
  assign busy = state_q == ACD_S_DECODE || state_q == ACD_S_EXEC ||
                state_q == ACD_S_DMA || state_q == ACD_S_END;
  assign dataReq = state_q == ACD_S_PIO;
  assign intReq = int_q;
  // Transfer window, no window at all for non-data or aborted commands
  assign xferActive = state_q == ACD_S_PIO || state_q == ACD_S_DMA;
  assign xferToHost = class_q == ACD_CLS_PIO_IN || ((class_q == ACD_CLS_DMA ||
                      class_q == ACD_CLS_QUEUED) && !opcode_q[0]);
  assign xferDma = state_q == ACD_S_DMA;
  assign cmdClass = class_q;
  // Priority is reported only, one command runs at a time so order is kept
  assign prioHigh = prio_q;

endmodule : acd_command_decoder
`default_nettype wire

// file: sim/acd_command_decoder_sva.sv
// Port-level protocol checks for the command class decoder
`timescale 1ns/1ps
`default_nettype none
module acd_command_decoder_sva
  import acd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic comReset,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic xferActive,
  input wire logic xferToHost,
  input wire logic xferDma,
  input wire logic busy,
  input wire logic dataReq,
  input wire logic intReq,
  input wire logic [2:0] cmdClass,
  input wire logic prioHigh
);
  // One clock domain, plain reset disables everything
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Status read accepted while nothing runs
  sequence s_stRead;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ACD_OFF_STATUS && !busy && !xferActive;
  endsequence
  // Command over, interrupt pending
  sequence s_done;
    !busy && !dataReq && intReq;
  endsequence
  property p_stClr;
    s_stRead |-> ##[1:2] !intReq;
  endproperty
  property p_comClr;
    comReset |=> !intReq && !busy && !dataReq && cmdClass == ACD_CLS_NONE;
  endproperty
  // Busy may only drop into a data phase or into completion with interrupt
  property p_busyEnd;
    disable iff (rst || comReset) $fell(busy) && !$past(rst) && !$past(comReset) |-> dataReq || intReq;
  endproperty
  // Data request may only drop into the busy ending step, unless a register reset fired
  property p_drqEnd;
    disable iff (rst || comReset)
    $fell(dataReq) && !$past(rst) && !$past(comReset) && !s_axi_bvalid && !$past(s_axi_bvalid) |-> busy;
  endproperty
  property p_noData;
    cmdClass == ACD_CLS_NODATA |-> !xferActive;
  endproperty
  property p_pioDir;
    xferActive && !xferDma |->
      (cmdClass == ACD_CLS_PIO_IN && xferToHost) || (cmdClass == ACD_CLS_PIO_OUT && !xferToHost);
  endproperty
  property p_dma;
    xferActive && xferDma |-> busy && !dataReq && (cmdClass == ACD_CLS_DMA || cmdClass == ACD_CLS_QUEUED);
  endproperty
  property p_prio;
    prioHigh |-> cmdClass == ACD_CLS_QUEUED;
  endproperty
  // Unknown opcode finishes quickly with the interrupt up
  property p_abort;
    disable iff (rst || comReset) busy && cmdClass == ACD_CLS_NONE |-> ##[1:3] s_done;
  endproperty
  a_stClr: assert property (p_stClr) else $error("status read left interrupt set");
  a_comClr: assert property (p_comClr) else $error("link reset did not clear state");
  a_busyEnd: assert property (p_busyEnd) else $error("busy fell without cover or interrupt");
  a_drqEnd: assert property (p_drqEnd) else $error("data request fell with busy low");
  a_noData: assert property (p_noData) else $error("non-data command opened data phase");
  a_pioDir: assert property (p_pioDir) else $error("PIO phase with wrong class or direction");
  a_dma: assert property (p_dma) else $error("DMA phase with wrong flags or class");
  a_prio: assert property (p_prio) else $error("priority reported on non-queued command");
  a_abort: assert property (p_abort) else $error("unknown opcode not ended in time");
endmodule : acd_command_decoder_sva
bind acd_command_decoder acd_command_decoder_sva u_acd_command_decoder_sva (.ref_clk, .rst, .comReset,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .xferActive, .xferToHost, .xferDma,
  .busy, .dataReq, .intReq, .cmdClass, .prioHigh);
`default_nettype wire

// file: sim/acd_media_model.sv
// Far-side word mover that paces data words during a data phase
`timescale 1ns/1ps
`default_nettype none
module acd_media_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic xferActive,
  input wire logic slow,
  input wire logic hold,
  output logic wordStrobe
);
  logic [1:0] gap_q; // Spacing counter between words
  // One word every second cycle, or every fourth when slow; silent when stalled
  always_ff @(posedge ref_clk) begin
    if (rst || !xferActive || hold) begin
      wordStrobe <= 1'b0;
      gap_q <= 2'h0;
    end else begin
      gap_q <= gap_q + 2'h1;
      wordStrobe <= slow ? (gap_q == 2'h3) : gap_q[0];
    end
  end
endmodule : acd_media_model
`default_nettype wire

// file: sim/tb_acd_command_decoder.sv
// Self-checking bench for the command class decoder
`timescale 1ns/1ps
`default_nettype none
module tb_acd_command_decoder
  import acd_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic comReset = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic wordStrobe, xferActive, xferToHost, xferDma, busy, dataReq, intReq, prioHigh;
  logic [2:0] cmdClass;
  logic slow = 1'b0, hold = 1'b0, dirSeen = 1'b0, dmaSeen = 1'b0;
  // Running tallies; strobes and actCycles written only by the recorder below, errors and samples_checked by chk, errors also by the hang guard
  int strobes = 0, actCycles = 0, errors = 0, samples_checked = 0;
  // Rows: opcode, feature, count, class
  localparam logic [39:0] cmdTable [17] = '{40'hf8_0000_00_03, 40'h27_0000_00_03, 40'h40_0000_00_03,
    40'h41_0000_00_03, 40'h42_0000_00_03, 40'hb4_0000_00_03, 40'hb4_0011_00_03, 40'hb4_0014_00_03,
    40'hb4_0020_00_03, 40'hb1_00c0_00_03, 40'hb1_00c1_00_03, 40'hb1_00c2_01_01, 40'hb1_00c3_02_02,
    40'hc8_0000_01_04, 40'h60_0001_80_05, 40'h61_0002_00_05, 40'hb4_0012_00_00};
  acd_command_decoder u_acd_command_decoder (.ref_clk, .rst, .comReset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wordStrobe, .xferActive, .xferToHost, .xferDma, .busy, .dataReq, .intReq, .cmdClass,
    .prioHigh);
  acd_media_model u_acd_media_model (.ref_clk, .rst, .xferActive, .slow, .hold, .wordStrobe);
  always #5 ref_clk = ~ref_clk;
  // Record data phase direction, kind and word count
  always @(posedge ref_clk) begin
    if (xferActive) begin
      actCycles <= actCycles + 1;
      dirSeen <= xferToHost;
      dmaSeen <= xferDma;
      if (wordStrobe) strobes <= strobes + 1;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Handshakes are judged at the falling edge, taken at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    done = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    logic ar, done;
    done = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge ref_clk);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // Host polls status until idle and ready before odd table rows and each reset pass
  task pollIdle;
    int n;
    n = 0;
    do begin
      rd(ACD_OFF_STATUS);
      n++;
    end while ((rdat[ACD_ST_BSY] || !rdat[ACD_ST_RDY] || rdat[ACD_ST_DRQ]) && n < 50);
    // A poll that ran out of tries counts as a mismatch here
    chk({rdat[ACD_ST_BSY], rdat[ACD_ST_RDY], rdat[ACD_ST_DRQ]}, 3'b010);
    @(negedge ref_clk);
    chk(intReq, 1'b0);
  endtask : pollIdle
  task runCmd(input logic [39:0] row, input logic poll);
    int n, exp, s0, a0;
    n = 0;
    exp = (row[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5}) ? 128 * (row[2:0] == 3'h5 ? row[23:16] : row[15:8]) : 0;
    if (poll) pollIdle;
    wr(ACD_OFF_FEAT, {16'h0, row[31:16]});
    wr(ACD_OFF_COUNT, {24'h0, row[15:8]});
    s0 = strobes;
    a0 = actCycles;
    wr(ACD_OFF_CMD, {24'h0, row[39:32]});
    @(negedge ref_clk);
    // Opcode write clears the interrupt; entry into a PIO data phase raises it again
    chk(intReq, row[2:0] inside {3'h1, 3'h2});
    chk(cmdClass, row[2:0]);
    chk(prioHigh, row[2:0] == 3'h5 && row[15]);
    while ((busy || dataReq) && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    // A command that never finished counts as a mismatch here
    chk(busy || dataReq, 1'b0);
    chk(intReq, 1'b1);
    chk(strobes - s0, exp);
    chk(actCycles != a0, exp != 0);
    if (exp != 0) chk({dirSeen, dmaSeen}, {row[2:0] == 3'h1 || (row[2:0] > 3'h3 && !row[32]), row[2:0] > 3'h3});
    rd(ACD_OFF_ERROR);
    chk(rdat[ACD_ER_ABRT], row[2:0] == 3'h0);
    rd(ACD_OFF_CLASS);
    chk(rdat[3:0], {row[2:0] == 3'h5 && row[15], row[2:0]});
  endtask : runCmd
  task tRegs;
    rd(8'h1c);
    chk(resp, ACD_RESP_SLVERR);
    chk(rdat, 32'h0);
    wr(ACD_OFF_STATUS, 32'h0);
    chk(resp, ACD_RESP_SLVERR);
    rd(ACD_OFF_STATUS);
    chk({rdat[ACD_ST_BSY], rdat[ACD_ST_RDY]}, 2'b01);
    $display("test regs done");
  endtask : tRegs
  task tTable;
    for (int i = 0; i < 17; i++) begin
      @(posedge ref_clk);
      slow <= i[1];
      runCmd(cmdTable[i], i[0]);
    end
    $display("test command table done");
  endtask : tTable
  // A stalled data phase is ended by software reset, then by link reset
  task tReset;
    for (int k = 0; k < 2; k++) begin
      pollIdle;
      wr(ACD_OFF_FEAT, {16'h0, 8'h00, ACD_CFG_IDENTIFY});
      wr(ACD_OFF_COUNT, 32'h1);
      @(posedge ref_clk);
      hold <= 1'b1;
      wr(ACD_OFF_CMD, 32'hb1);
      repeat (4) @(negedge ref_clk);
      chk({dataReq, intReq}, 2'b11);
      if (k == 0) begin
        rd(ACD_OFF_STATUS);
        @(negedge ref_clk);
        chk({rdat[ACD_ST_DRQ], intReq}, 2'b10);
      end
      wr(ACD_OFF_FEAT, 32'h55);
      @(negedge ref_clk);
      chk(dataReq, 1'b1);
      if (k == 0) wr(ACD_OFF_CTRL, 32'h1 << ACD_CT_SRST);
      else begin
        @(posedge ref_clk);
        comReset <= 1'b1;
        @(posedge ref_clk);
        comReset <= 1'b0;
      end
      @(negedge ref_clk);
      chk({busy, dataReq, intReq, cmdClass}, 6'h0);
      @(posedge ref_clk);
      hold <= 1'b0;
    end
    $display("test reset abort done");
  endtask : tReset
  task conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    tRegs;
    tTable;
    tReset;
    conclude;
  end
  // Hang guard well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    conclude;
  end
endmodule : tb_acd_command_decoder
`default_nettype wire
